// ### hw/hmcg_top.v
// hmcg_top.v: halt-mode standby gating with the cpu on the subsystem clock
// assumes: oscillator status, pin levels and interrupt lines are asynchronous;
// cpu-side controls (halt strobe, selects, port data) are on i_clk
// outputs are flip-flop levels, except the one-cycle wake pulses
`timescale 1ns/1ps
`include "hmcg_defines.vh"
// Overview of operation
// - halt on subsystem clock enters halt mode
// - cpu clock gated off during halt
// - port latches hold pre-halt values
// - timer 00 runs only while main osc runs
// - timer 50 needs external input without osc
// - timer 51 needs external input without osc
// - serial channel needs external clock when stopped
// - uarts need running timer 50 output clock
// - option selects stoppable or fixed ring oscillator
// - ring stopped only if stoppable and stopped
// - timer unit needs subsystem source without osc
// - unmasked interrupt releases halt, vector or next
// - reset releases halt and restarts at vector
module hmcg_top #(
  parameter       PORT_W        = 8,
  parameter       IRQ_W         = 8,
  parameter [0:0] RING_STOPPABLE = 1'b1
) (
  input  wire              i_clk,
  input  wire              i_srst,
  input  wire              i_halt_exec,
  input  wire              i_cpu_on_subclk,
  input  wire              i_main_osc_input_run,
  input  wire              i_ring_sw_stop,
  input  wire [1:0]        i_timer50_clk_sel,
  input  wire [1:0]        i_timer51_clk_sel,
  input  wire              i_csi_clk_ext_sel,
  input  wire [1:0]        i_uart_a_clk_sel,
  input  wire [1:0]        i_uart_b_clk_sel,
  input  wire [1:0]        i_timer_unit_src_sel,
  input  wire [IRQ_W-1:0]  i_irq_req,
  input  wire [IRQ_W-1:0]  i_irq_mask,
  input  wire              i_irq_ack_en,
  input  wire [PORT_W-1:0] i_port_data,
  output reg               o_halted,
  output reg               o_cpu_clk_en,
  output reg  [PORT_W-1:0] o_port_latch,
  output reg               o_timer00_en,
  output reg               o_timer50_en,
  output reg               o_timer51_en,
  output reg               o_csi_en,
  output reg               o_uart_a_en,
  output reg               o_uart_b_en,
  output reg               o_timer_unit_en,
  output reg               o_clk_monitor_en,
  output reg               o_internal_ring_oscillator_run,
  output reg               o_ext_int_en,
  output reg               o_lvd_en,
  output reg               o_wake_vector,
  output reg               o_wake_next,
  output reg               o_reset_vector
);
  localparam ST_RUN  = `HMCG_ST_RUN;
  localparam ST_HALT = `HMCG_ST_HALT;

  wire [IRQ_W+1:0] sync_w;
  wire             osc_run;
  wire             ring_req_stop;
  wire [IRQ_W-1:0] irq_s;

  hmcg_sync #(
    .W(IRQ_W+2)
  ) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_irq_req, i_ring_sw_stop, i_main_osc_input_run}),
    .o_sync  (sync_w)
  );
  assign osc_run       = sync_w[0];
  assign ring_req_stop = sync_w[1];
  assign irq_s         = sync_w[IRQ_W+1:2];

  // registered state and helpers
  reg  state_q;
  reg  state_d;
  wire irq_hit;
  wire ring_stopped;
  wire int_stopped;
  wire halt;
  wire t50_run;

  // next values of the registered outputs
  wire halted_d;
  wire cpu_clk_en_d;
  wire timer00_en_d;
  wire timer50_en_d;
  wire timer51_en_d;
  wire csi_en_d;
  wire uart_a_en_d;
  wire uart_b_en_d;
  wire timer_unit_en_d;
  wire clk_monitor_en_d;
  wire internal_ring_oscillator_run_d;
  wire wake_vector_d;
  wire wake_next_d;

  // release request and oscillator state
  assign irq_hit      = |(irq_s & ~i_irq_mask);
  assign ring_stopped = RING_STOPPABLE & ring_req_stop;
  assign int_stopped  = ~osc_run | ring_stopped;
  assign halt         = (state_q == ST_HALT);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (i_halt_exec && i_cpu_on_subclk) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (irq_hit) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // cpu-side next values
  assign halted_d         = (state_d == ST_HALT);
  assign cpu_clk_en_d     = (state_d != ST_HALT);

  // peripheral gating next values, one cycle behind state
  assign timer00_en_d     = ~halt | osc_run;
  assign t50_run          = ~halt | osc_run |
                            (i_timer50_clk_sel == `HMCG_T5X_SEL_EXT);
  assign timer50_en_d     = t50_run;
  assign timer51_en_d     = ~halt | osc_run |
                            (i_timer51_clk_sel == `HMCG_T5X_SEL_EXT);
  assign csi_en_d         = ~halt | ~int_stopped |
                            i_csi_clk_ext_sel;
  assign uart_a_en_d      = ~halt | ~int_stopped |
                            ((i_uart_a_clk_sel == `HMCG_UART_SEL_T50) & t50_run);
  assign uart_b_en_d      = ~halt | ~int_stopped |
                            ((i_uart_b_clk_sel == `HMCG_UART_SEL_T50) & t50_run);
  assign timer_unit_en_d  = ~halt | osc_run |
                            (i_timer_unit_src_sel == `HMCG_TU_SEL_SUB);
  assign clk_monitor_en_d = ~(halt & ring_stopped);
  assign internal_ring_oscillator_run_d   = ~ring_stopped;

  // wake pulse next values
  assign wake_vector_d    = halt & irq_hit & i_irq_ack_en;
  assign wake_next_d      = halt & irq_hit & ~i_irq_ack_en;

  // state, cpu clock and reset vector
  always @(posedge i_clk) begin
    if (i_srst) begin
      state_q        <= ST_RUN;
      o_halted       <= `HMCG_RST_GATE;
      o_cpu_clk_en   <= `HMCG_RST_EN;
      o_reset_vector <= `HMCG_RST_RVEC;
    end else begin
      state_q        <= state_d;
      o_halted       <= halted_d;
      o_cpu_clk_en   <= cpu_clk_en_d;
      o_reset_vector <= 1'h0;
    end
  end

  // port output latch, frozen while halted
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_port_latch <= {PORT_W{1'b0}};
    end else begin
      if (state_d != ST_HALT) begin
        o_port_latch <= i_port_data;
      end
    end
  end

  // peripheral gating
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_timer00_en     <= `HMCG_RST_EN;
      o_timer50_en     <= `HMCG_RST_EN;
      o_timer51_en     <= `HMCG_RST_EN;
      o_csi_en         <= `HMCG_RST_EN;
      o_uart_a_en      <= `HMCG_RST_EN;
      o_uart_b_en      <= `HMCG_RST_EN;
      o_timer_unit_en  <= `HMCG_RST_EN;
      o_clk_monitor_en <= `HMCG_RST_EN;
      o_internal_ring_oscillator_run   <= `HMCG_RST_EN;
    end else begin
      o_timer00_en     <= timer00_en_d;
      o_timer50_en     <= timer50_en_d;
      o_timer51_en     <= timer51_en_d;
      o_csi_en         <= csi_en_d;
      o_uart_a_en      <= uart_a_en_d;
      o_uart_b_en      <= uart_b_en_d;
      o_timer_unit_en  <= timer_unit_en_d;
      o_clk_monitor_en <= clk_monitor_en_d;
      o_internal_ring_oscillator_run   <= internal_ring_oscillator_run_d;
    end
  end

  // always-on blocks and wake pulses
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_ext_int_en  <= `HMCG_RST_EN;
      o_lvd_en      <= `HMCG_RST_EN;
      o_wake_vector <= `HMCG_RST_WAKE;
      o_wake_next   <= `HMCG_RST_WAKE;
    end else begin
      o_ext_int_en  <= 1'h1;
      o_lvd_en      <= 1'h1;
      o_wake_vector <= wake_vector_d;
      o_wake_next   <= wake_next_d;
    end
  end
endmodule

// ### hw/hmcg_defines.vh
// hmcg_defines.vh: constants for the halt-mode clock gating block
// assumes: included by bare name from the design files under hw/
`ifndef HMCG_DEFINES_VH
`define HMCG_DEFINES_VH
// cpu run state codes
`define HMCG_ST_RUN       1'b0
`define HMCG_ST_HALT      1'b1
// reset values
`define HMCG_RST_GATE     1'b0
`define HMCG_RST_PORT     8'h00
`define HMCG_RST_EN       1'h1
`define HMCG_RST_WAKE     1'h0
`define HMCG_RST_RVEC     1'h1
// synchroniser depth
`define HMCG_SYNC_STAGES  2
// timer 50/51 count clock select codes
`define HMCG_T5X_SEL_EXT  2'h3
// uart baud clock select code for timer 50 output
`define HMCG_UART_SEL_T50 2'h3
// timer unit source select code for the subsystem clock
`define HMCG_TU_SEL_SUB   2'h1
`endif

// ### hw/hmcg_sync.v
// hmcg_sync.v: two-stage level synchroniser, one bit per lane
// assumes: inputs come from outside the i_clk domain
`timescale 1ns/1ps
module hmcg_sync #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_srst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

// ### test/hmcg_properties.sv
// hmcg_properties.sv: port checker for hmcg_top
// assumes: bound into hmcg_top below, sees only its ports
`timescale 1ns/1ps
module hmcg_properties #(
  parameter PORT_W = 8
) (
  input wire              i_clk,
  input wire              i_srst,
  input wire              i_halt_exec,
  input wire              i_cpu_on_subclk,
  input wire              o_halted,
  input wire              o_cpu_clk_en,
  input wire [PORT_W-1:0] o_port_latch,
  input wire              o_timer00_en,
  input wire              o_csi_en,
  input wire              o_uart_a_en,
  input wire              o_clk_monitor_en,
  input wire              o_ext_int_en,
  input wire              o_lvd_en,
  input wire              o_wake_vector,
  input wire              o_wake_next
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire all_on   = o_timer00_en & o_csi_en & o_uart_a_en & o_clk_monitor_en;
  wire halt_req = i_halt_exec & i_cpu_on_subclk;
  wire woke     = o_wake_vector | o_wake_next;
  a_halt_entry: assert property (!o_halted && halt_req |=> o_halted)
    else $error("halt not entered");
  a_halt_refused: assert property (!o_halted && !i_cpu_on_subclk |=> !o_halted)
    else $error("halt entered off subclock");
  a_cpu_clk_gate: assert property (o_cpu_clk_en == !o_halted)
    else $error("cpu clock not gated");
  a_port_hold: assert property (o_halted && $past(o_halted) |-> $stable(o_port_latch))
    else $error("port latch moved in halt");
  a_run_all_on: assert property (!$past(o_halted) |-> all_on)
    else $error("peripheral gated while running");
  a_always_on: assert property (o_lvd_en && o_ext_int_en)
    else $error("detect or interrupt gated");
  a_wake_cause: assert property (woke |-> $past(o_halted) && !o_halted)
    else $error("wake without release");
  a_wake_one: assert property (!(o_wake_vector && o_wake_next))
    else $error("both wake kinds");
  c_halt: cover property ($rose(o_halted));
  c_vec: cover property (o_wake_vector);
  c_next: cover property (o_wake_next);
endmodule
bind hmcg_top hmcg_properties #(
  .PORT_W (PORT_W)
) u_chk (
  .i_clk            (i_clk),
  .i_srst           (i_srst),
  .i_halt_exec      (i_halt_exec),
  .i_cpu_on_subclk  (i_cpu_on_subclk),
  .o_halted         (o_halted),
  .o_cpu_clk_en     (o_cpu_clk_en),
  .o_port_latch     (o_port_latch),
  .o_timer00_en     (o_timer00_en),
  .o_csi_en         (o_csi_en),
  .o_uart_a_en      (o_uart_a_en),
  .o_clk_monitor_en (o_clk_monitor_en),
  .o_ext_int_en     (o_ext_int_en),
  .o_lvd_en         (o_lvd_en),
  .o_wake_vector    (o_wake_vector),
  .o_wake_next      (o_wake_next)
);

// ### test/testbench.sv
// testbench.sv: random halt, gating, wake and reset runs on hmcg_top
// assumes: default parameters, internal_ring_oscillator stoppable by software
`timescale 1ns/1ps
module testbench;
  logic       i_clk = 0, i_srst = 1, i_halt_exec = 0, i_cpu_on_subclk = 1, i_irq_ack_en = 0;
  logic       i_main_osc_input_run = 1, i_ring_sw_stop = 0, i_csi_clk_ext_sel = 0;
  logic [1:0] i_timer50_clk_sel = 0, i_timer51_clk_sel = 0, i_uart_a_clk_sel = 0;
  logic [1:0] i_uart_b_clk_sel = 0, i_timer_unit_src_sel = 0;
  logic [7:0] i_irq_req = 0, i_irq_mask = 0, i_port_data = 0;
  wire  [7:0] o_port_latch;
  wire        o_halted, o_cpu_clk_en, o_timer00_en, o_timer50_en, o_timer51_en, o_csi_en;
  wire        o_uart_a_en, o_uart_b_en, o_timer_unit_en, o_clk_monitor_en, o_internal_ring_oscillator_run;
  wire        o_ext_int_en, o_lvd_en, o_wake_vector, o_wake_next, o_reset_vector;
  logic [31:0] r = 32'h6070_0368;
  int         errors = 0, checked = 0, k;
  hmcg_top uut (
    .i_clk                (i_clk),
    .i_srst               (i_srst),
    .i_halt_exec          (i_halt_exec),
    .i_cpu_on_subclk      (i_cpu_on_subclk),
    .i_main_osc_input_run (i_main_osc_input_run),
    .i_ring_sw_stop       (i_ring_sw_stop),
    .i_timer50_clk_sel    (i_timer50_clk_sel),
    .i_timer51_clk_sel    (i_timer51_clk_sel),
    .i_csi_clk_ext_sel    (i_csi_clk_ext_sel),
    .i_uart_a_clk_sel     (i_uart_a_clk_sel),
    .i_uart_b_clk_sel     (i_uart_b_clk_sel),
    .i_timer_unit_src_sel (i_timer_unit_src_sel),
    .i_irq_req            (i_irq_req),
    .i_irq_mask           (i_irq_mask),
    .i_irq_ack_en         (i_irq_ack_en),
    .i_port_data          (i_port_data),
    .o_halted             (o_halted),
    .o_cpu_clk_en         (o_cpu_clk_en),
    .o_port_latch         (o_port_latch),
    .o_timer00_en         (o_timer00_en),
    .o_timer50_en         (o_timer50_en),
    .o_timer51_en         (o_timer51_en),
    .o_csi_en             (o_csi_en),
    .o_uart_a_en          (o_uart_a_en),
    .o_uart_b_en          (o_uart_b_en),
    .o_timer_unit_en      (o_timer_unit_en),
    .o_clk_monitor_en     (o_clk_monitor_en),
    .o_internal_ring_oscillator_run       (o_internal_ring_oscillator_run),
    .o_ext_int_en         (o_ext_int_en),
    .o_lvd_en             (o_lvd_en),
    .o_wake_vector        (o_wake_vector),
    .o_wake_next          (o_wake_next),
    .o_reset_vector       (o_reset_vector)
  );
  initial forever #4 i_clk = ~i_clk;
  function automatic [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected enables in halt from the packed selects
  function automatic [8:0] gates(input [31:0] s);
    logic o, rs, is, t50;
    o = s[0]; rs = s[1]; is = !o | rs; t50 = o | s[3:2] == 2'h3;
    gates = {o, t50, o | s[5:4] == 2'h3, !is | s[6], !is | s[8:7] == 2'h3 & t50,
             !is | s[10:9] == 2'h3 & t50, o | s[12:11] == 2'h1, !rs, !rs};
  endfunction
  task cyc(input int n); repeat (n) @(posedge i_clk); #1; endtask
  task ck(input [15:0] g, input [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin #100000; errors++; wrap_up; end
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 0;
    for (k = 0; k < 24; k++) begin
      r = nx(r);
      if (k < 4) r[1:0] = k;
      @(posedge i_clk);
      {i_timer_unit_src_sel, i_uart_b_clk_sel, i_uart_a_clk_sel, i_csi_clk_ext_sel,
       i_timer51_clk_sel, i_timer50_clk_sel, i_ring_sw_stop, i_main_osc_input_run} <= r[12:0];
      i_port_data <= r[20:13];
      i_irq_ack_en <= r[21];
      i_irq_mask <= 8'hff;
      i_cpu_on_subclk <= k % 6 != 5;
      cyc(4);
      @(posedge i_clk) i_halt_exec <= 1;
      @(posedge i_clk) begin i_halt_exec <= 0; i_port_data <= ~r[20:13]; end
      cyc(5);
      ck(o_halted, k % 6 != 5);
      if (k % 6 == 5) continue;
      ck({o_cpu_clk_en, o_port_latch}, {1'b0, r[20:13]});
      ck({o_timer00_en, o_timer50_en, o_timer51_en, o_csi_en, o_uart_a_en, o_uart_b_en,
          o_timer_unit_en, o_clk_monitor_en, o_internal_ring_oscillator_run}, gates(r));
      if (k % 6 == 2) begin
        @(posedge i_clk) i_srst <= 1;
        cyc(1);
        ck({o_halted, o_reset_vector}, 2'b01);
        @(posedge i_clk) i_srst <= 0;
        cyc(3);
        ck({o_reset_vector, o_halted, o_ext_int_en, o_lvd_en}, 4'b0011);
        continue;
      end
      @(posedge i_clk) i_irq_req <= 8'h01 << r[24:22];
      cyc(6);
      ck(o_halted, 1);
      @(posedge i_clk) i_irq_mask <= ~(8'h01 << r[24:22]);
      for (int w = 0; w < 10 && !(o_wake_vector | o_wake_next); w++) cyc(1);
      ck({o_halted, o_wake_vector, o_wake_next}, {1'b0, r[21], !r[21]});
      @(posedge i_clk) i_irq_req <= 0;
      cyc(4);
    end
    wrap_up;
  end
endmodule
